// ### design/pcsi_regs.svh
// Purpose: offsets, field positions, reset values and sizes for the program counter, stack and indirect block
// Assumes: 32-bit apb with one aligned word per register
// Notes:   definitions only
`ifndef PCSI_REGS_SVH
`define PCSI_REGS_SVH

// ==========================================================
// sizes
`define PCSI_PC_W        13
`define PCSI_STACK_DEPTH 8
`define PCSI_INT_VECTOR  13'h0004

// ==========================================================
// apb byte offsets
`define PCSI_OFF_PCLOW   12'h000
`define PCSI_OFF_PC_HIGH_LATCH  12'h004
`define PCSI_OFF_FSR     12'h008
`define PCSI_OFF_BANK    12'h00C
`define PCSI_OFF_PCFULL  12'h010

// ==========================================================
// file addresses seen by instructions (low seven bits, mirrored in every bank)
`define PCSI_FA_INDIRECT_DATA_PORT     7'h00
`define PCSI_FA_PCL      7'h02
`define PCSI_FA_STATUS   7'h03
`define PCSI_FA_FSR      7'h04
`define PCSI_FA_PC_HIGH_LATCH   7'h0A

// ==========================================================
// field positions
`define PCSI_STAT_IRP    7
`define PCSI_STAT_RP_HI  6
`define PCSI_STAT_RP_LO  5
`define PCSI_CG_HI       4
`define PCSI_CG_LO       3

// ==========================================================
// reset values
`define PCSI_PC_RST      13'h0000
`define PCSI_PC_HIGH_LATCH_RST  5'h00
`define PCSI_FSR_RST     8'h00
`define PCSI_BANK_RST    3'h0

`endif

// ### design/pcsi_pkg.sv
// Purpose: shared types of the program counter, stack and indirect block
// Assumes: nothing
// Notes:   constants live in pcsi_regs.svh
package pcsi_pkg;
  typedef logic [12:0] pcsi_pc_t;
  typedef enum logic [2:0] {
    PCSI_HOLD,
    PCSI_STEP,
    PCSI_JUMP,
    PCSI_LATCHED,
    PCSI_CALL,
    PCSI_RET,
    PCSI_VECTOR
  } pcsi_pcsrc_t;
endpackage : pcsi_pkg

// ### design/pcsi_ret_stack.sv
// Purpose: circular hardware return stack
// Assumes: push and pop never in the same cycle
// Notes:   no overflow or underflow indication by design
`timescale 1ns/10ps
`default_nettype none
`include "pcsi_regs.svh"
module pcsi_ret_stack #(
  parameter int WIDTH = `PCSI_PC_W,
  parameter int DEPTH = `PCSI_STACK_DEPTH
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // push and pop
  input  wire logic             pushEn,
  input  wire logic [WIDTH-1:0] pushData,
  input  wire logic             popEn,
  output logic      [WIDTH-1:0] topData
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] entry_ff [DEPTH];
  logic [PW-1:0]    ptr_ff;
  logic [PW-1:0]    topIdx;

  // ==========================================================
  // pointer wraps, so the ninth push lands on the first slot
  assign topIdx  = ptr_ff - PW'(1);
  assign topData = entry_ff[topIdx];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ptr_ff <= '0;
    end else if (pushEn) begin
      ptr_ff <= ptr_ff + PW'(1);
    end else if (popEn) begin
      ptr_ff <= topIdx;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        entry_ff[i] <= '0;
      end
    end else if (pushEn) begin
      entry_ff[ptr_ff] <= pushData;
    end
  end
endmodule : pcsi_ret_stack
`default_nettype wire

// ### design/pcsi_core.sv
// Purpose: program counter, return stack control and indirect data addressing
// Assumes: decoder raises at most one flow strobe per cycle; one instruction per clk
// Notes:   apb slave with no wait states; memory address outputs lag the request by one clk
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "pcsi_regs.svh"

module pcsi_core #(
  parameter int                DEPTH      = `PCSI_STACK_DEPTH,
  parameter pcsi_pkg::pcsi_pc_t INT_VECTOR = `PCSI_INT_VECTOR
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // instruction flow from the decoder
  input  wire logic        stepEn,
  input  wire logic        callEn,
  input  wire logic        gotoEn,
  input  wire logic        retEn,
  input  wire logic        intEn,
  input  wire logic [10:0] jumpTarget,
  output logic      [12:0] pcOut,
  // data file access from the decoder
  input  wire logic [6:0]  fileAddr,
  input  wire logic        fileRdEn,
  input  wire logic        fileWrEn,
  input  wire logic [7:0]  fileWrData,
  // data memory side
  output logic      [8:0]  memAddr,
  output logic             memRdEn,
  output logic             memWrEn,
  output logic      [7:0]  memWrData,
  output logic             memRdZero
);

  // ==========================================================
  // state
  pcsi_pkg::pcsi_pc_t    pc_ff;
  pcsi_pkg::pcsi_pc_t    nxt_pc;
  pcsi_pkg::pcsi_pcsrc_t pcSrc;
  logic [4:0]            pc_high_latch_ff;
  logic [7:0]            fsr_ff;
  logic [2:0]            bank_ff;
  logic [31:0]           prdata_ff;
  logic                  pslverr_ff;
  logic [8:0]            memAddr_ff;
  logic                  memRdEn_ff;
  logic                  memWrEn_ff;
  logic [7:0]            memWrData_ff;
  logic                  memRdZero_ff;

  // ==========================================================
  // helpers
  function automatic logic fa_hit(input logic [8:0] addr, input logic [6:0] code);
    fa_hit = (addr[6:0] == code);
  endfunction : fa_hit

  function automatic logic off_hit(input logic [11:0] addr, input logic [11:0] off);
    off_hit = (addr == off);
  endfunction : off_hit

  // ==========================================================
  // effective data address
  logic       isIndirect;
  logic       indSelf;
  logic [8:0] effAddr;
  logic       coreWr;
  logic       coreRd;

  assign isIndirect = (fileAddr == `PCSI_FA_INDIRECT_DATA_PORT);
  assign indSelf    = isIndirect && (fsr_ff[6:0] == `PCSI_FA_INDIRECT_DATA_PORT);
  always_comb begin
    if (isIndirect) begin
      effAddr = {bank_ff[2], fsr_ff};
    end else begin
      effAddr = {bank_ff[1:0], fileAddr};
    end
  end
  // a write through the port onto itself is dropped; the decoder may still set flags
  assign coreWr = fileWrEn && !indSelf;
  assign coreRd = fileRdEn;

  // ==========================================================
  // apb decode: setup phase latches read data, access phase completes
  logic apbSetup;
  logic apbWr;
  logic apbMapped;

  assign apbSetup  = psel && !penable;
  assign apbWr     = psel && penable && pwrite;
  assign apbMapped = off_hit(paddr, `PCSI_OFF_PCLOW) || off_hit(paddr, `PCSI_OFF_PC_HIGH_LATCH)
                  || off_hit(paddr, `PCSI_OFF_FSR) || off_hit(paddr, `PCSI_OFF_BANK)
                  || off_hit(paddr, `PCSI_OFF_PCFULL);
  assign pready  = psel && penable;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff && pready;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (apbSetup) begin
      pslverr_ff <= !apbMapped;
      if (off_hit(paddr, `PCSI_OFF_PCLOW)) begin
        prdata_ff <= {24'h000000, pc_ff[7:0]};
      end else if (off_hit(paddr, `PCSI_OFF_PC_HIGH_LATCH)) begin
        prdata_ff <= {27'h0000000, pc_high_latch_ff};
      end else if (off_hit(paddr, `PCSI_OFF_FSR)) begin
        prdata_ff <= {24'h000000, fsr_ff};
      end else if (off_hit(paddr, `PCSI_OFF_BANK)) begin
        prdata_ff <= {24'h000000, bank_ff, 5'h00};
      end else if (off_hit(paddr, `PCSI_OFF_PCFULL)) begin
        prdata_ff <= {19'h00000, pc_ff};
      end else begin
        prdata_ff <= 32'h00000000;
      end
    end
  end

  // ==========================================================
  // writes to pc low, from an instruction or from apb; instruction wins
  logic       coreWrPcl;
  logic       pclWr;
  logic [7:0] pclData;

  assign coreWrPcl = coreWr && fa_hit(effAddr, `PCSI_FA_PCL);
  assign pclWr     = coreWrPcl || (apbWr && off_hit(paddr, `PCSI_OFF_PCLOW));
  assign pclData   = coreWrPcl ? fileWrData : pwdata[7:0];

  // ==========================================================
  // program counter source select
  pcsi_pkg::pcsi_pc_t stackTop;
  logic               pushEn;

  always_comb begin
    if (retEn) begin
      pcSrc = pcsi_pkg::PCSI_RET;
    end else if (intEn) begin
      pcSrc = pcsi_pkg::PCSI_VECTOR;
    end else if (callEn) begin
      pcSrc = pcsi_pkg::PCSI_CALL;
    end else if (gotoEn) begin
      pcSrc = pcsi_pkg::PCSI_JUMP;
    end else if (pclWr) begin
      pcSrc = pcsi_pkg::PCSI_LATCHED;
    end else if (stepEn) begin
      pcSrc = pcsi_pkg::PCSI_STEP;
    end else begin
      pcSrc = pcsi_pkg::PCSI_HOLD;
    end
  end

  always_comb begin
    case (pcSrc)
      pcsi_pkg::PCSI_RET:     nxt_pc = stackTop;
      pcsi_pkg::PCSI_VECTOR:  nxt_pc = INT_VECTOR;
      pcsi_pkg::PCSI_CALL,
      pcsi_pkg::PCSI_JUMP:    nxt_pc = {pc_high_latch_ff[`PCSI_CG_HI:`PCSI_CG_LO], jumpTarget};
      // offset added by the alu lands here; no carry into the upper bits
      pcsi_pkg::PCSI_LATCHED: nxt_pc = {pc_high_latch_ff, pclData};
      pcsi_pkg::PCSI_STEP:    nxt_pc = pc_ff + 13'h0001;
      pcsi_pkg::PCSI_HOLD:    nxt_pc = pc_ff;
      default:                nxt_pc = pc_ff;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_ff <= `PCSI_PC_RST;
    end else begin
      pc_ff <= nxt_pc;
    end
  end
  assign pcOut = pc_ff;

  // ==========================================================
  // return stack; the pointer has no software path at all
  assign pushEn = (callEn || intEn) && !retEn;

  pcsi_ret_stack #(
    .WIDTH (`PCSI_PC_W),
    .DEPTH (DEPTH)
  ) u_stack (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pushEn   (pushEn),
    .pushData (pc_ff),
    .popEn    (retEn),
    .topData  (stackTop)
  );

  // ==========================================================
  // special registers; only explicit writes touch the latch, never stack traffic
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_high_latch_ff <= `PCSI_PC_HIGH_LATCH_RST;
    end else if (coreWr && fa_hit(effAddr, `PCSI_FA_PC_HIGH_LATCH)) begin
      pc_high_latch_ff <= fileWrData[4:0];
    end else if (apbWr && off_hit(paddr, `PCSI_OFF_PC_HIGH_LATCH)) begin
      pc_high_latch_ff <= pwdata[4:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fsr_ff <= `PCSI_FSR_RST;
    end else if (coreWr && fa_hit(effAddr, `PCSI_FA_FSR)) begin
      fsr_ff <= fileWrData;
    end else if (apbWr && off_hit(paddr, `PCSI_OFF_FSR)) begin
      fsr_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bank_ff <= `PCSI_BANK_RST;
    end else if (coreWr && fa_hit(effAddr, `PCSI_FA_STATUS)) begin
      bank_ff <= fileWrData[`PCSI_STAT_IRP:`PCSI_STAT_RP_LO];
    end else if (apbWr && off_hit(paddr, `PCSI_OFF_BANK)) begin
      bank_ff <= pwdata[`PCSI_STAT_IRP:`PCSI_STAT_RP_LO];
    end
  end

  // ==========================================================
  // data memory request, registered
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      memAddr_ff   <= 9'h000;
      memRdEn_ff   <= 1'b0;
      memWrEn_ff   <= 1'b0;
      memWrData_ff <= 8'h00;
      memRdZero_ff <= 1'b0;
    end else begin
      memAddr_ff   <= effAddr;
      memRdEn_ff   <= coreRd && !indSelf;
      memWrEn_ff   <= coreWr;
      memWrData_ff <= fileWrData;
      memRdZero_ff <= coreRd && indSelf;
    end
  end
  assign memAddr   = memAddr_ff;
  assign memRdEn   = memRdEn_ff;
  assign memWrEn   = memWrEn_ff;
  assign memWrData = memWrData_ff;
  assign memRdZero = memRdZero_ff;

  // ==========================================================
  // checks
  a_pc_reset: assert property (@(posedge clk) sys_rst |=> pcOut == 13'h0000)
    else $error("pc not cleared by reset");

  a_pcl_load: assert property (@(posedge clk) disable iff (sys_rst)
    (pcSrc == pcsi_pkg::PCSI_LATCHED) |=> pcOut == {$past(pc_high_latch_ff), $past(pclData)})
    else $error("pc low write did not load latch bits");

  a_goto_load: assert property (@(posedge clk) disable iff (sys_rst)
    (gotoEn && !callEn && !intEn && !retEn)
      |=> pcOut == {$past(pc_high_latch_ff[4:3]), $past(jumpTarget)})
    else $error("goto target wrong");

  a_call_return: assert property (@(posedge clk) disable iff (sys_rst)
    (callEn && !intEn && !retEn) ##1 (retEn && !callEn) |=> pcOut == $past(pcOut, 2))
    else $error("return did not restore pushed pc");

  a_latch_kept: assert property (@(posedge clk) disable iff (sys_rst)
    ((callEn || retEn || intEn) && !fileWrEn && !apbWr) |=> $stable(pc_high_latch_ff))
    else $error("latch changed by stack traffic");

  a_self_rd_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (fileRdEn && isIndirect && fsr_ff[6:0] == 7'h00) |=> memRdZero && !memRdEn)
    else $error("self indirect read not zero");

  a_self_wr_drop: assert property (@(posedge clk) disable iff (sys_rst)
    (fileWrEn && isIndirect && fsr_ff[6:0] == 7'h00) |=> !memWrEn)
    else $error("self indirect write reached memory");

  a_ind_addr: assert property (@(posedge clk) disable iff (sys_rst)
    ((fileRdEn || fileWrEn) && isIndirect) |=> memAddr == {$past(bank_ff[2]), $past(fsr_ff)})
    else $error("indirect address wrong");

  a_dir_bank: assert property (@(posedge clk) disable iff (sys_rst)
    ((fileRdEn || fileWrEn) && !isIndirect) |=> memAddr == {$past(bank_ff[1:0]), $past(fileAddr)})
    else $error("direct bank wrong");

endmodule : pcsi_core
`default_nettype wire

// ### tb/pcsi_mem_model.sv
// Purpose: data memory seen by the core, answering reads one clk after the strobe
// Assumes: core presents registered address and strobes
// Notes:   no answer pending shows a toggling byte so stale data never passes
`timescale 1ns/10ps
`default_nettype none
module pcsi_mem_model (
  // clock
  input  wire logic       clk,
  // core memory side
  input  wire logic [8:0] memAddr,
  input  wire logic       memRdEn,
  input  wire logic       memWrEn,
  input  wire logic [7:0] memWrData,
  input  wire logic       memRdZero,
  // read answer
  output logic      [7:0] rdData
);
  logic [7:0] mem [512];
  logic [7:0] idleByte = 8'hA5;
  // ==========================================================
  // storage and answer
  always @(posedge clk) begin
    if (memWrEn) begin
      mem[memAddr] <= memWrData;
    end
    rdData   <= memRdZero ? 8'h00 : (memRdEn ? mem[memAddr] : idleByte);
    idleByte <= ~idleByte;
  end
endmodule : pcsi_mem_model
`default_nettype wire

// ### tb/tb.sv
// Purpose: self-checking bench for the program counter, stack and indirect block
// Assumes: apb answers after one access cycle; mem outputs lag one clk
// Notes:   integer model of pc, stack, pointer and ram is compared at every step
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        sysRst = 1'b1;
  logic [11:0] paddr = '0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [31:0] pwdata = '0, prdata, rd, rs = 32'h000008E5;
  logic        stepEn = 0, callEn = 0, gotoEn = 0, retEn = 0, intEn = 0;
  logic [10:0] jumpTarget = '0;
  logic [12:0] pcOut;
  logic [6:0]  fileAddr = '0;
  logic        fileRdEn = 0, fileWrEn = 0, memRdEn, memWrEn, memRdZero;
  logic [7:0]  fileWrData = '0, memWrData, rdData;
  logic [8:0]  memAddr;
  int          nMismatch = 0, nChecks = 0, pc = 0, lat = 0, file_select_pointer = 0, bank = 0, sp = 0, i, v;
  int          stk[8];
  int          ram[int];
  always #12.5 clk = ~clk;
  pcsi_core dut_u (.clk(clk), .sys_rst(sysRst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stepEn(stepEn), .callEn(callEn), .gotoEn(gotoEn), .retEn(retEn), .intEn(intEn),
    .jumpTarget(jumpTarget), .pcOut(pcOut), .fileAddr(fileAddr), .fileRdEn(fileRdEn),
    .fileWrEn(fileWrEn), .fileWrData(fileWrData), .memAddr(memAddr), .memRdEn(memRdEn),
    .memWrEn(memWrEn), .memWrData(memWrData), .memRdZero(memRdZero));
  pcsi_mem_model mem_u (.clk(clk), .memAddr(memAddr), .memRdEn(memRdEn), .memWrEn(memWrEn),
    .memWrData(memWrData), .memRdZero(memRdZero), .rdData(rdData));
  // ==========================================================
  // helpers
  function automatic int rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return int'(rs & 32'h7FFFFFFF);
  endfunction : rnd
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic endSim();
    $display("checks %0d mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : endSim
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) nMismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // s = {fileWr, fileRd, int, ret, goto, call, step}
  task automatic pulse(input logic [6:0] s, input logic [10:0] t, input logic [6:0] a, input logic [7:0] d);
    int ad, ea;
    logic z;
    z = (a == 0) && (file_select_pointer % 128 == 0);
    ad = (a == 0) ? (bank / 4) * 256 + file_select_pointer : (bank % 4) * 128 + a;
    ea = (a == 0) ? file_select_pointer % 128 : a;
    @(posedge clk);
    {fileWrEn, fileRdEn, intEn, retEn, gotoEn, callEn, stepEn} <= s;
    jumpTarget <= t;
    fileAddr <= a;
    fileWrData <= d;
    @(posedge clk);
    {fileWrEn, fileRdEn, intEn, retEn, gotoEn, callEn, stepEn} <= '0;
    if (s[3]) begin
      sp = (sp + 7) % 8;
      pc = stk[sp];
    end else if (s[4] || s[1]) begin
      stk[sp] = pc;
      sp = (sp + 1) % 8;
      pc = s[4] ? 4 : (lat & 24) * 256 + t;
    end else if (s[2]) pc = (lat & 24) * 256 + t;
    else if (s[6] && !z && ea == 2) pc = lat * 256 + d;
    else if (s[0]) pc = (pc + 1) % 8192;
    if (s[6] && !z && ea == 3) bank = d / 32;
    if (s[6] && !z && ea == 4) file_select_pointer = d;
    if (s[6] && !z && ea == 10) lat = d % 32;
    if (s[6] && !z && ad % 128 >= 32) ram[ad] = d;
    #1;
    chk("pc", pcOut, pc);
    if (s[6:5] != 0) chk("addr", memAddr, ad);
    if (s[5]) chk("rdzero", memRdZero, z);
    if (s[6]) chk("wren", memWrEn, !z);
    if (s[6]) chk("wrdata", memWrData, d);
    if (s[5]) chk("rden", memRdEn, !z);
    if (s[5] && (z || ram.exists(ad))) begin
      @(posedge clk);
      #1;
      chk("rdata", rdData, z ? 0 : ram[ad]);
    end
  endtask : pulse
  // ==========================================================
  // watchdog
  initial begin
    #(25 * 20000);
    nMismatch++;
    endSim();
  end
  // ==========================================================
  // scenarios
  initial begin
    repeat (2) @(posedge clk);
    sysRst <= 1'b0;
    #1 chk("pc reset", pcOut, 0);
    lat = rnd() % 32;
    apb(1'b1, 12'h004, lat);
    v = rnd() % 256;
    apb(1'b1, 12'h000, v);
    pc = lat * 256 + v;
    apb(1'b0, 12'h000, 0);
    chk("pc low", rd, v);
    apb(1'b1, 12'h010, 32'h00001FFF);
    apb(1'b0, 12'h010, 0);
    chk("pc full", rd, pc);
    apb(1'b0, 12'h014, 0);
    chk("unmapped", {rd[30:0], err}, 1);
    for (i = 0; i < 4; i++) begin
      pulse(7'h01, 0, 0, 0);
      pulse(7'h04, rnd() % 2048, 0, 0);
    end
    for (i = 0; i < 10; i++) pulse(7'h02, rnd() % 2048, 0, 0);
    pulse(7'h10, 0, 0, 0);
    for (i = 0; i < 11; i++) pulse(7'h08, 0, 0, 0);
    // call followed at once by a return must give back the pushed pc
    @(posedge clk);
    callEn     <= 1'b1;
    jumpTarget <= 11'h155;
    @(posedge clk);
    callEn <= 1'b0;
    retEn  <= 1'b1;
    @(posedge clk);
    retEn <= 1'b0;
    stk[sp] = pc;
    #1 chk("call ret", pcOut, pc);
    apb(1'b0, 12'h004, 0);
    chk("latch", rd, lat);
    pulse(7'h40, 0, 7'h02, rnd() % 256);
    pulse(7'h40, 0, 7'h0A, rnd() % 256);
    pulse(7'h40, 0, 7'h02, rnd() % 256);
    pulse(7'h02, rnd() % 2048, 0, 0);
    pulse(7'h40, 0, 7'h04, rnd() % 256);
    apb(1'b0, 12'h008, 0);
    chk("fsr core", rd, file_select_pointer);
    pulse(7'h40, 0, 7'h03, rnd() % 256);
    apb(1'b0, 12'h00C, 0);
    chk("bank core", rd, bank * 32);
    bank = 4;
    apb(1'b1, 12'h00C, 32'h00000080);
    for (i = 0; i < 8; i++) begin
      file_select_pointer = 32 + i;
      apb(1'b1, 12'h008, file_select_pointer);
      pulse(7'h40, 0, 0, rnd() % 256);
      pulse(7'h20, 0, 0, 0);
    end
    file_select_pointer = 0;
    apb(1'b1, 12'h008, 0);
    pulse(7'h20, 0, 0, 0);
    pulse(7'h40, 0, 0, 8'hFF);
    for (i = 0; i < 4; i++) begin
      bank = i;
      apb(1'b1, 12'h00C, i * 32);
      pulse(7'h20, 0, 32 + rnd() % 8, 0);
    end
    apb(1'b0, 12'h00C, 0);
    chk("bank", rd, 96);
    // second reset in mid-run clears pc and the special registers again
    sysRst <= 1'b1;
    repeat (2) @(posedge clk);
    sysRst <= 1'b0;
    pc = 0;
    lat = 0;
    file_select_pointer = 0;
    bank = 0;
    sp = 0;
    #1 chk("pc rerun", pcOut, pc);
    apb(1'b0, 12'h004, 0);
    chk("latch reset", rd, lat);
    apb(1'b0, 12'h00C, 0);
    chk("bank reset", rd, bank);
    pulse(7'h01, 0, 0, 0);
    endSim();
  end
endmodule : tb
`default_nettype wire
